// file: verilog/nsefr_consts.vh
`ifndef NSEFR_CONSTS_VH
`define NSEFR_CONSTS_VH
// feature addresses
`define NSEFR_FA_STATUS 8'hC0
`define NSEFR_FA_DRIVE 8'hD0
`define NSEFR_FA_CONFIG 8'hB0
`define NSEFR_FA_ECCEXT 8'hF0
// command codes on the serial link
`define NSEFR_CMD_FREAD 8'h0F
`define NSEFR_CMD_FWRITE 8'h1F
`define NSEFR_CMD_WREN 8'h06
`define NSEFR_CMD_WRDI 8'h04
`define NSEFR_CMD_RESET 8'hFF
`define NSEFR_CMD_PROG 8'h10
`define NSEFR_CMD_READ 8'h13
`define NSEFR_CMD_ERASE 8'hD8
// status bit positions
`define NSEFR_ST_BUSY 0
`define NSEFR_ST_WLATCH 1
`define NSEFR_ST_EFAIL 2
`define NSEFR_ST_PFAIL 3
`define NSEFR_ST_CS_LO 4
`define NSEFR_ST_CS_HI 5
// other field positions
`define NSEFR_DS_LO 5
`define NSEFR_DS_HI 6
`define NSEFR_CFG_ECC_EN 4
`define NSEFR_EXT_LO 4
`define NSEFR_EXT_HI 5
// reset values
`define NSEFR_RST_DRIVE 2'b00
`define NSEFR_RST_ECC_EN 1'b1
// cache byte map
`define NSEFR_SPARE_BASE 13'h1000
`define NSEFR_PARITY_BASE 13'h1080
`define NSEFR_PARITY_LAST 13'h10FF
`define NSEFR_BAD_MARK 8'h00
`define NSEFR_BAD_MARK_ADDR 13'h1000
`endif

// file: verilog/nsefr_top.v
// How it works
// - status byte read via feature-read at C0h
// - drive select at D0h, read and write
// - program fail set on failure or lock
// - program fail cleared by program, reset
// - erase fail set on failure or lock
// - write enable latch gates program, erase
// - busy flag high during array operations
// - correction status zeroed, then updated on read
// - correction status meaningless with correction off
// - status after reset reflects page zero load
// - codes 00 and 01 with extension
// - codes 10 uncorrected, 11 eight corrected
// - correction enabled at power-up, feature bit
// - program computes code over cache page
// - read recomputes, corrects, outputs corrected data
// - protected byte map of main and spare
// - parity area writes ignored when correcting
// - factory bad mark 00h at byte 4096
`timescale 1ns/1ns
`include "nsefr_consts.vh"
module nsefr_top (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // serial link
    input wire i_sclk,
    input wire i_cs_n,
    input wire i_mosi,
    output reg o_miso,
    output reg o_miso_oe_n,
    // array engine handshake
    output reg o_prog_start,
    output reg o_read_start,
    output reg o_erase_start,
    output reg [23:0] o_row_addr,
    input wire i_op_done,
    input wire i_op_fail,
    input wire i_addr_locked,
    input wire [3:0] i_err_count,
    input wire i_uncorrectable,
    // cache port and feature outputs
    input wire [12:0] i_cache_addr,
    input wire i_cache_we,
    output reg o_cache_we,
    output reg o_cache_protected,
    output reg o_ecc_enable,
    output reg [1:0] o_drive_sel
);

// ---------------------------------------------------------
// link synchronisers
// ---------------------------------------------------------
reg [1:0] sclk_s_r;
reg [1:0] cs_s_r;
reg [1:0] mosi_s_r;
reg sclk_d_r;
reg cs_d_r;
wire rise = sclk_s_r[1] & ~sclk_d_r;
wire fall = ~sclk_s_r[1] & sclk_d_r;
wire sel = ~cs_s_r[1];
wire frame_end = cs_s_r[1] & ~cs_d_r;

// two stages before anything looks at the pins
always @(posedge i_mclk) begin
    if (i_rst) begin
        sclk_s_r <= 2'b00;
        cs_s_r <= 2'b11;
        mosi_s_r <= 2'b00;
        sclk_d_r <= 1'b0;
        cs_d_r <= 1'b1;
    end else begin
        sclk_s_r <= {sclk_s_r[0], i_sclk};
        cs_s_r <= {cs_s_r[0], i_cs_n};
        mosi_s_r <= {mosi_s_r[0], i_mosi};
        sclk_d_r <= sclk_s_r[1];
        cs_d_r <= cs_s_r[1];
    end
end

// ---------------------------------------------------------
// byte assembly
// ---------------------------------------------------------
reg [7:0] sh_r;
reg [2:0] bit_r;
reg [2:0] byte_r;
reg [7:0] cmd_r;
reg [7:0] fa_r;
reg [23:0] adr_r;
wire [7:0] sh_nxt = {sh_r[6:0], mosi_s_r[1]};
wire byte_done = sel & rise & (bit_r == 3'd7);

// byte count saturates at 7; later bytes only repeat the read
always @(posedge i_mclk) begin
    if (i_rst || !sel) begin
        sh_r <= 8'h00;
        bit_r <= 3'd0;
        byte_r <= 3'd0;
    end else if (rise) begin
        sh_r <= sh_nxt;
        bit_r <= bit_r + 3'd1;
        if (bit_r == 3'd7 && byte_r != 3'd7)
            byte_r <= byte_r + 3'd1;
    end
end

// command, feature address and row address capture
always @(posedge i_mclk) begin
    if (i_rst) begin
        cmd_r <= 8'h00;
        fa_r <= 8'h00;
        adr_r <= 24'h00_0000;
    end else if (byte_done) begin
        if (byte_r == 3'd0)
            cmd_r <= sh_nxt;
        if (byte_r == 3'd1)
            fa_r <= sh_nxt;
        if (byte_r >= 3'd1 && byte_r <= 3'd3)
            adr_r <= {adr_r[15:0], sh_nxt};
    end
end

// ---------------------------------------------------------
// feature registers and status flags
// ---------------------------------------------------------
localparam ST_IDLE = 2'd0;
localparam ST_BUSY = 2'd1;
localparam ST_RDBUSY = 2'd2;
localparam OP_PROG = 2'd0;
localparam OP_READ = 2'd1;
localparam OP_ERASE = 2'd2;
localparam OP_RESET = 2'd3;

reg [1:0] st_r;
reg [1:0] op_r;
reg write_enable_latch_r;
reg pfail_r;
reg efail_r;
reg [1:0] cs_main_r;
reg [1:0] cs_ext_r;
reg [7:0] stat_byte;
reg [7:0] rd_byte;

wire is_fw = frame_end & (cmd_r == `NSEFR_CMD_FWRITE) & (byte_r >= 3'd3);
wire go = frame_end & (st_r == ST_IDLE);
wire c_prog = go & (cmd_r == `NSEFR_CMD_PROG) & (byte_r >= 3'd4);
wire c_read = go & (cmd_r == `NSEFR_CMD_READ) & (byte_r >= 3'd4);
wire c_erase = go & (cmd_r == `NSEFR_CMD_ERASE) & (byte_r >= 3'd4);
wire c_reset = frame_end & (cmd_r == `NSEFR_CMD_RESET);
// program and erase proceed only with the latch set
wire p_ok = c_prog & write_enable_latch_r & ~i_addr_locked;
wire e_ok = c_erase & write_enable_latch_r & ~i_addr_locked;
wire p_lock = c_prog & write_enable_latch_r & i_addr_locked;
wire e_lock = c_erase & write_enable_latch_r & i_addr_locked;
wire done = (st_r != ST_IDLE) & i_op_done;

// drive strength and correction enable, writable by feature write
always @(posedge i_mclk) begin
    if (i_rst) begin
        o_drive_sel <= `NSEFR_RST_DRIVE;
        o_ecc_enable <= `NSEFR_RST_ECC_EN;
    end else if (is_fw) begin
        if (fa_r == `NSEFR_FA_DRIVE)
            o_drive_sel <= adr_r[`NSEFR_DS_HI:`NSEFR_DS_LO];
        if (fa_r == `NSEFR_FA_CONFIG)
            o_ecc_enable <= adr_r[`NSEFR_CFG_ECC_EN];
        // writes aimed at the status address fall through here
    end
end

// write enable latch
always @(posedge i_mclk) begin
    if (i_rst)
        write_enable_latch_r <= 1'b0;
    else if (go && cmd_r == `NSEFR_CMD_WREN)
        write_enable_latch_r <= 1'b1;
    else if (go && cmd_r == `NSEFR_CMD_WRDI)
        write_enable_latch_r <= 1'b0;
    else if (p_ok || e_ok || c_reset)
        write_enable_latch_r <= 1'b0;
end

// fail flags: a set from the engine beats any clear in that cycle
always @(posedge i_mclk) begin
    if (i_rst) begin
        pfail_r <= 1'b0;
        efail_r <= 1'b0;
    end else begin
        if ((done && op_r == OP_PROG && i_op_fail) || p_lock)
            pfail_r <= 1'b1;
        else if (p_ok || c_reset)
            pfail_r <= 1'b0;
        if ((done && op_r == OP_ERASE && i_op_fail) || e_lock)
            efail_r <= 1'b1;
        else if (e_ok || c_reset)
            efail_r <= 1'b0;
    end
end

// operation sequencer; after reset release page zero is loaded
always @(posedge i_mclk) begin
    if (i_rst) begin
        st_r <= ST_RDBUSY;
        op_r <= OP_READ;
        o_prog_start <= 1'b0;
        o_read_start <= 1'b1;
        o_erase_start <= 1'b0;
        o_row_addr <= 24'h00_0000;
    end else begin
        o_prog_start <= 1'b0;
        o_read_start <= 1'b0;
        o_erase_start <= 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (p_ok) begin
                    // engine encodes the cache page first
                    st_r <= ST_BUSY;
                    op_r <= OP_PROG;
                    o_prog_start <= 1'b1;
                    o_row_addr <= adr_r;
                end else if (c_read) begin
                    st_r <= ST_RDBUSY;
                    op_r <= OP_READ;
                    o_read_start <= 1'b1;
                    o_row_addr <= adr_r;
                end else if (e_ok) begin
                    st_r <= ST_BUSY;
                    op_r <= OP_ERASE;
                    o_erase_start <= 1'b1;
                    o_row_addr <= adr_r;
                end else if (c_reset) begin
                    st_r <= ST_BUSY;
                    op_r <= OP_RESET;
                end
            end
            ST_BUSY, ST_RDBUSY: begin
                if (c_reset) begin
                    // abort; engine must answer with done
                    st_r <= ST_BUSY;
                    op_r <= OP_RESET;
                end else if (i_op_done) begin
                    st_r <= ST_IDLE;
                end
            end
            default: begin
                st_r <= ST_IDLE;
            end
        endcase
    end
end

// correction status: cleared at read start, encoded at read end
always @(posedge i_mclk) begin
    if (i_rst || c_reset || c_read) begin
        cs_main_r <= 2'b00;
        cs_ext_r <= 2'b00;
    end else if (done && op_r == OP_READ && o_ecc_enable) begin
        // with correction off the fields stay at 00
        if (i_uncorrectable) begin
            cs_main_r <= 2'b10;
            cs_ext_r <= 2'b00;
        end else if (i_err_count == 4'd8) begin
            cs_main_r <= 2'b11;
            cs_ext_r <= 2'b00;
        end else if (i_err_count == 4'd0) begin
            cs_main_r <= 2'b00;
            cs_ext_r <= 2'b00;
        end else begin
            cs_main_r <= 2'b01;
            if (i_err_count <= 4'd4)
                cs_ext_r <= 2'b00;
            else
                cs_ext_r <= i_err_count[1:0];
        end
    end
end

// ---------------------------------------------------------
// feature read mux
// ---------------------------------------------------------
// the address byte is still landing in fa_r when the first
// answer byte is loaded, so take it straight from the shifter
wire [7:0] fa_w = (byte_done && byte_r == 3'd1) ? sh_nxt : fa_r;

always @* begin
    stat_byte = 8'h00;
    stat_byte[`NSEFR_ST_BUSY] = (st_r != ST_IDLE);
    stat_byte[`NSEFR_ST_WLATCH] = write_enable_latch_r;
    stat_byte[`NSEFR_ST_EFAIL] = efail_r;
    stat_byte[`NSEFR_ST_PFAIL] = pfail_r;
    stat_byte[`NSEFR_ST_CS_HI:`NSEFR_ST_CS_LO] = cs_main_r;
    case (fa_w)
        `NSEFR_FA_STATUS: rd_byte = stat_byte;
        `NSEFR_FA_DRIVE: rd_byte = {1'b0, o_drive_sel, 5'b0_0000};
        `NSEFR_FA_CONFIG: rd_byte = {3'b000, o_ecc_enable, 4'h0};
        `NSEFR_FA_ECCEXT: rd_byte = {2'b00, cs_ext_r, 4'h0};
        default: rd_byte = 8'h00; // unmapped address reads zero
    endcase
end

// ---------------------------------------------------------
// serial output
// ---------------------------------------------------------
reg [7:0] tx_r;
reg [2:0] txc_r;
reg tx_on_r;

// loaded after the address byte, refreshed every byte so a
// long read keeps polling live status
always @(posedge i_mclk) begin
    if (i_rst || !sel) begin
        tx_r <= 8'h00;
        txc_r <= 3'd0;
        tx_on_r <= 1'b0;
        o_miso <= 1'b0;
        o_miso_oe_n <= 1'b1;
    end else if (byte_done && byte_r == 3'd1 &&
                 cmd_r == `NSEFR_CMD_FREAD) begin
        tx_on_r <= 1'b1;
        txc_r <= 3'd0;
        tx_r <= rd_byte;
    end else if (fall && tx_on_r) begin
        o_miso <= tx_r[7];
        o_miso_oe_n <= 1'b0;
        txc_r <= txc_r + 3'd1;
        if (txc_r == 3'd7)
            tx_r <= rd_byte;
        else
            tx_r <= {tx_r[6:0], 1'b0};
    end
end

// ---------------------------------------------------------
// cache byte map
// ---------------------------------------------------------
wire in_parity = (i_cache_addr >= `NSEFR_PARITY_BASE) &&
                 (i_cache_addr <= `NSEFR_PARITY_LAST);
wire in_meta1 = (i_cache_addr >= `NSEFR_SPARE_BASE) &&
                (i_cache_addr < `NSEFR_PARITY_BASE) &&
                (i_cache_addr[3:2] == 2'b00);

// mark byte sits in unprotected meta so it survives
always @(posedge i_mclk) begin
    if (i_rst) begin
        o_cache_we <= 1'b0;
        o_cache_protected <= 1'b0;
    end else begin
        o_cache_we <= i_cache_we & ~(o_ecc_enable & in_parity);
        o_cache_protected <= ~in_meta1 &&
            (i_cache_addr <= `NSEFR_PARITY_LAST);
    end
end

endmodule // nsefr_top

// file: verification/nsefr_top_sva.sv
`timescale 1ns/1ns
module nsefr_top_chk (
    // clock and reset
    input wire i_mclk,
    input wire i_rst,
    // watched pins
    input wire [12:0] i_cache_addr,
    input wire i_cache_we,
    input wire o_miso_oe_n,
    input wire o_prog_start,
    input wire o_read_start,
    input wire o_erase_start,
    input wire o_cache_we,
    input wire o_cache_protected,
    input wire o_ecc_enable,
    input wire [1:0] o_drive_sel
);
    // parity window and protected map of the cache page
    wire par_w = i_cache_addr >= 13'h1080 && i_cache_addr <= 13'h10FF;
    wire prot_w = i_cache_addr <= 13'h10FF &&
        !(i_cache_addr[12] && !i_cache_addr[7] && i_cache_addr[3:2] == 2'h0);
    default clocking cb @(posedge i_mclk); endclocking
    // reset values, seen one edge after reset is sampled
    a_ecc_on_rst: assert property (i_rst |=> o_ecc_enable)
        else $error("correction off after reset");
    a_drive_rst: assert property (i_rst |=> o_drive_sel == 2'b00)
        else $error("drive select not cleared");
    a_page0_load: assert property (i_rst ##1 i_rst |-> o_read_start)
        else $error("no page zero load in reset");
    a_miso_rst: assert property (i_rst |=> o_miso_oe_n)
        else $error("serial output driven in reset");
    // parity bytes dropped only while correcting
    a_parity_drop: assert property (disable iff (i_rst)
        i_cache_we && o_ecc_enable && par_w |=> !o_cache_we)
        else $error("parity write passed");
    a_cache_pass: assert property (disable iff (i_rst)
        i_cache_we && !(o_ecc_enable && par_w) |=> o_cache_we)
        else $error("cache write lost");
    a_prot_map: assert property (disable iff (i_rst)
        i_cache_we |=> o_cache_protected == $past(prot_w))
        else $error("protected flag wrong");
    a_one_start: assert property (disable iff (i_rst)
        $onehot0({o_prog_start, o_read_start, o_erase_start}))
        else $error("two array starts at once");
endmodule // nsefr_top_chk

bind nsefr_top nsefr_top_chk u_chk (.i_mclk, .i_rst, .i_cache_addr,
    .i_cache_we, .o_miso_oe_n, .o_prog_start, .o_read_start,
    .o_erase_start, .o_cache_we, .o_cache_protected, .o_ecc_enable,
    .o_drive_sel);

// file: verification/nsefr_host.sv
`timescale 1ns/1ns
// host end of the serial link, mode 0, one frame per call
module nsefr_host (
    // serial link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b1;
    end
    // n bytes out msb first; with r, eight more clocks read a byte
    task automatic xfer(input logic [31:0] d, input int n,
        output logic [7:0] q, input bit r = 1'b0);
        int lo;
        lo = r ? -8 : 0;
        o_cs_n = 1'b0;
        for (int i = n * 8 - 1; i >= lo; i--) begin
            o_mosi = i >= 0 ? d[i] : ~o_mosi;
            #62 o_sclk = 1'b1;
            q = {q[6:0], i_miso};
            #63 o_sclk = 1'b0;
        end
        // clock parks low; data flips so no stale level lingers
        #62 o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        #250;
    endtask
endmodule // nsefr_host

// file: verification/tb_nand_status_ecc_feature_regs.sv
`timescale 1ns/1ns
module tb_nand_status_ecc_feature_regs;
    logic i_mclk, i_rst, i_op_done, i_op_fail, i_addr_locked;
    logic i_uncorrectable, i_cache_we;
    logic [3:0] i_err_count;
    logic [12:0] i_cache_addr;
    logic [7:0] rx;
    logic [23:0] row;
    logic [2:0] seen;
    logic [15:0] exp_q[$];
    logic [3:0] ec[5] = '{4'h0, 4'h5, 4'h7, 4'h8, 4'h9};
    logic [7:0] cs_t[5] = '{8'h00, 8'h10, 8'h10, 8'h30, 8'h20};
    int failures, samples_checked, seed;
    event got;
    wire i_sclk, i_cs_n, i_mosi, o_miso, o_miso_oe_n, o_prog_start;
    wire o_read_start, o_erase_start, o_cache_we, o_cache_protected;
    wire o_ecc_enable;
    wire [1:0] o_drive_sel;
    wire [23:0] o_row_addr;
    wire [2:0] starts = {o_erase_start, o_read_start, o_prog_start};
    // a released line shows the inverse of its last level
    wire miso_w = o_miso_oe_n ? ~o_miso : o_miso;
    nsefr_top dut (.i_mclk, .i_rst, .i_sclk, .i_cs_n, .i_mosi, .o_miso,
        .o_miso_oe_n, .o_prog_start, .o_read_start, .o_erase_start,
        .o_row_addr, .i_op_done, .i_op_fail, .i_addr_locked, .i_err_count,
        .i_uncorrectable, .i_cache_addr, .i_cache_we, .o_cache_we,
        .o_cache_protected, .o_ecc_enable, .o_drive_sel);
    nsefr_host host (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_mosi(i_mosi),
        .i_miso(miso_w));
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // start pulses are short, so they are caught here
    always @(posedge i_mclk) seen <= seen | starts;
    // oldest note against each byte the host reads back
    always @(got) begin
        chk("feature byte", exp_q[0][7:0], rx & exp_q[0][15:8]);
        void'(exp_q.pop_front());
    end
    task automatic chk(input string nm, input logic [23:0] e, g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic fr(input logic [7:0] a, e, m);
        exp_q.push_back({m, e});
        host.xfer({8'h0F, a}, 2, rx, 1'b1);
        ->got;
    endtask
    // engine answer; uncorrectable follows from a count above eight
    task automatic eng(input int k, input logic f, input logic [3:0] c);
        @(negedge i_mclk);
        if (k >= 0) chk("start pulse", 3'b001 << k, seen);
        seen = 3'b000;
        @(posedge i_mclk);
        i_op_done <= 1'b1;
        i_op_fail <= f;
        i_err_count <= c;
        i_uncorrectable <= c > 4'h8;
        @(posedge i_mclk);
        i_op_done <= 1'b0;
    endtask
    // random cache writes, a quarter of them into the parity bytes
    task automatic cache;
        repeat (60) begin
            @(posedge i_mclk);
            i_cache_we <= 1'($random(seed));
            i_cache_addr <= 13'h0F00 + 13'({$random(seed)} % 512);
        end
        @(posedge i_mclk);
        i_cache_we <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        seed = 45769;
        {i_rst, i_op_done, i_op_fail, i_addr_locked} = 4'h8;
        {i_uncorrectable, i_cache_we, seen} = 5'h00;
        i_err_count = 4'h0;
        i_cache_addr = 13'h0000;
        repeat (8) @(posedge i_mclk);
        chk("drive reset", 2'b00, o_drive_sel);
        chk("ecc reset", 1'b1, o_ecc_enable);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        fr(8'hC0, 8'h01, 8'h3F);
        eng(-1, 1'b0, 4'h6);
        fr(8'hC0, 8'h10, 8'h3F);
        fr(8'hF0, 8'h20, 8'h30);
        for (int v = 0; v < 4; v++) begin
            row[7:0] = 8'($random(seed)) & 8'h9F | 8'(v << 5);
            host.xfer({8'h1F, 8'hD0, row[7:0]}, 3, rx);
            fr(8'hD0, 8'(v << 5), 8'h60);
            chk("drive select", v[1:0], o_drive_sel);
        end
        host.xfer({8'h1F, 8'hC0, 8'hFF}, 3, rx);
        fr(8'hC0, 8'h10, 8'h3F);
        host.xfer(8'h06, 1, rx);
        fr(8'hC0, 8'h12, 8'h3F);
        host.xfer(8'h04, 1, rx);
        fr(8'hC0, 8'h10, 8'h3F);
        row = 24'($random(seed));
        host.xfer({8'hD8, row}, 4, rx);
        fr(8'hC0, 8'h10, 8'h3F);
        chk("start without latch", 3'b000, seen);
        @(posedge i_mclk);
        i_addr_locked <= 1'b1;
        host.xfer(8'h06, 1, rx);
        host.xfer({8'h10, row}, 4, rx);
        fr(8'hC0, 8'h18, 8'h3D);
        host.xfer(8'h06, 1, rx);
        host.xfer({8'hD8, row}, 4, rx);
        fr(8'hC0, 8'h1C, 8'h3D);
        chk("refused start", 3'b000, seen);
        @(posedge i_mclk);
        i_addr_locked <= 1'b0;
        host.xfer(8'h06, 1, rx);
        host.xfer({8'h10, row}, 4, rx);
        fr(8'hC0, 8'h15, 8'h3F);
        eng(0, 1'b1, 4'h0);
        chk("row address", row, o_row_addr);
        fr(8'hC0, 8'h1C, 8'h3F);
        host.xfer(8'h06, 1, rx);
        host.xfer({8'hD8, row}, 4, rx);
        fr(8'hC0, 8'h19, 8'h3F);
        eng(2, 1'b0, 4'h0);
        fr(8'hC0, 8'h18, 8'h3F);
        for (int j = 0; j < 5; j++) begin
            row = 24'($random(seed));
            host.xfer({8'h13, row}, 4, rx);
            fr(8'hC0, 8'h01, 8'h31);
            eng(1, 1'b0, ec[j]);
            fr(8'hC0, cs_t[j], 8'h31);
            if (cs_t[j] == 8'h10)
                fr(8'hF0, {2'b00, ec[j][1:0], 4'h0}, 8'h30);
        end
        host.xfer(8'hFF, 1, rx);
        fr(8'hC0, 8'h01, 8'h01);
        eng(-1, 1'b0, 4'h0);
        fr(8'hC0, 8'h00, 8'h3F);
        cache;
        // the mark byte must stay writable and outside correction
        @(posedge i_mclk);
        i_cache_addr <= 13'h1000;
        i_cache_we <= 1'b1;
        @(posedge i_mclk);
        i_cache_we <= 1'b0;
        @(negedge i_mclk);
        chk("mark byte protect", 1'b0, o_cache_protected);
        chk("mark byte write", 1'b1, o_cache_we);
        host.xfer({8'h1F, 8'hB0, 8'h00}, 3, rx);
        fr(8'hB0, 8'h00, 8'h10);
        chk("ecc enable", 1'b0, o_ecc_enable);
        // a read with correction off leaves the status fields cleared
        host.xfer({8'h13, row}, 4, rx);
        eng(1, 1'b0, 4'h5);
        fr(8'hC0, 8'h00, 8'h31);
        cache;
        host.xfer({8'h1F, 8'hB0, 8'h10}, 3, rx);
        chk("ecc enable", 1'b1, o_ecc_enable);
        wrap_up;
    end
    // hang guard, well beyond the frames above
    initial begin
        #400_000;
        failures++;
        wrap_up;
    end
endmodule // tb_nand_status_ecc_feature_regs
